// ---- design/arsp_regs.svh ----
// arsp_regs.svh: timing counts and data-format constants of the serial result port.
// assumes: the port runs on the converter master clock; counts are in master clocks, except the HALF ones (half clocks) and the sync count (conversion cycles).
`ifndef ARSP_REGS_SVH
`define ARSP_REGS_SVH

// result word
`define ARSP_RESULT_W 24
`define ARSP_SUM_W 25
`define ARSP_ZERO_CODE 24'h000000
`define ARSP_POS_FS_CODE 24'h7FFFFF
`define ARSP_NEG_FS_CODE 24'h800000

// conversion cycle partitioning, in master clocks
`define ARSP_T_CYCLE_CLK 384
`define ARSP_T_READY_CLK 36
`define ARSP_T_SHIFT_CLK 348
`define ARSP_T1_WRITE_CLK 6
`define ARSP_T2_LOW_CLK 6
`define ARSP_T3_HIGH_CLK 6
`define ARSP_T4_HIGH_CLK 24

// sync and power-down, in master clocks (half-clock figures kept as twice the value; sync count in conversion cycles)
`define ARSP_T11_PULSE_CLK 3
`define ARSP_T12_MIN_CLK 1537
`define ARSP_T12_MAX_CLK 7679
`define ARSP_T14_HALF_CLK 405
`define ARSP_T15_MIN_CLK 7681
`define ARSP_T16_HALF_CLK 4637
`define ARSP_T17_HALF_CLK 12289
`define ARSP_SYNC_CYCLES 4

// falling-edge counter width on the serial clock side
`define ARSP_EDGE_CNT_W 4

`endif

// ---- design/arsp_pkg.sv ----
// arsp_pkg: types shared by the serial result port files.
// assumes: included constants come from arsp_regs.svh.
package arsp_pkg;

  // one-hot sequencer states
  typedef enum logic [4:0] {
    ARSP_RUN = 5'h01,
    ARSP_SYNC_PULSE = 5'h02,
    ARSP_SYNC_HOLD = 5'h04,
    ARSP_POWER_DOWN = 5'h08,
    ARSP_WAKE = 5'h10
  } arsp_state_type;

  typedef logic [23:0] arsp_result_type;

endpackage

// ---- design/arsp_sclk_edge_counter.sv ----
// arsp_sclk_edge_counter: counts falling edges of the serial clock, gray coded.
// assumes: the serial clock may stop between frames; the count is read through a
// two-flop synchroniser per bit in the master clock domain.
`timescale 1ns/1ps
`include "arsp_regs.svh"

module arsp_sclk_edge_counter (
  input wire logic sclk,
  input wire logic rst_n,
  output logic [`ARSP_EDGE_CNT_W-1:0] edge_gray_q
);

  logic [`ARSP_EDGE_CNT_W-1:0] edge_bin_q;
  logic [`ARSP_EDGE_CNT_W-1:0] edge_bin_d;

  assign edge_bin_d = edge_bin_q + `ARSP_EDGE_CNT_W'(1);

  // data leaves on falling edges, so count those; gray keeps one bit changing per step
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      edge_bin_q <= '0;
      edge_gray_q <= '0;
    end else begin
      edge_bin_q <= edge_bin_d;
      edge_gray_q <= edge_bin_d ^ (edge_bin_d >> 1);
    end
  end

endmodule // arsp_sclk_edge_counter

// ---- design/arsp_result_port.sv ----
// arsp_result_port: combined ready/shift-out result line of a delta-sigma converter.
// assumes: clock is the local master clock; sclk comes from the reader and only
// runs during reads or is held high to request sync or power-down.
`timescale 1ns/1ps
`include "arsp_regs.svh"

module arsp_result_port
  import arsp_pkg::*;
#(
  parameter int unsigned PD_GAP_CLK = (`ARSP_T17_HALF_CLK + 1) / 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic [`ARSP_SUM_W-1:0] filter_sum,
  output logic combined_result_line,
  output logic result_ready_phase,
  output logic modulator_reset,
  output logic power_down
);

  localparam int EW = `ARSP_EDGE_CNT_W;
  localparam logic [8:0] CYC_LAST = 9'(`ARSP_T_CYCLE_CLK - 1);
  localparam logic [8:0] CYC_T4_END = 9'(`ARSP_T4_HIGH_CLK);
  localparam logic [8:0] CYC_WRITE = 9'(`ARSP_T4_HIGH_CLK - 1);
  localparam logic [8:0] CYC_WRITE_START = 9'(`ARSP_T4_HIGH_CLK - `ARSP_T1_WRITE_CLK);
  localparam logic [8:0] CYC_LOW_END = 9'(`ARSP_T4_HIGH_CLK + `ARSP_T2_LOW_CLK);
  localparam logic [8:0] CYC_READY_END = 9'(`ARSP_T_READY_CLK);
  localparam logic [4:0] PTR_DONE = 5'(`ARSP_RESULT_W);
  localparam logic [12:0] HOLD_TRIG = 13'(`ARSP_SYNC_CYCLES * `ARSP_T_CYCLE_CLK + 1);
  localparam logic [12:0] PULSE_LAST = 13'(`ARSP_T11_PULSE_CLK - 1);
  localparam logic [12:0] GAP_LAST = 13'(PD_GAP_CLK - 1);
  localparam logic [12:0] WAKE_SYNC_LAST = 13'((`ARSP_T14_HALF_CLK + 1) / 2 - 1);
  localparam logic [12:0] WAKE_PD_LAST = 13'((`ARSP_T16_HALF_CLK + 1) / 2 - 1);

  // gray count of serial falling edges back to binary
  function automatic logic [EW-1:0] gray_to_bin(input logic [EW-1:0] g);
    logic [EW-1:0] b;
    b = '0;
    b[EW-1] = g[EW-1];
    for (int i = EW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // one result bit picked by the shift pointer
  function automatic logic result_bit(input arsp_result_type r, input logic [4:0] p);
    logic [4:0] idx;
    idx = 5'(`ARSP_RESULT_W - 1) - p;
    return r[idx];
  endfunction

  logic [EW-1:0] edge_gray;
  logic [EW-1:0] edge_meta_q;
  logic [EW-1:0] edge_sync_q;
  logic [EW-1:0] edge_bin_prev_q;
  logic [EW-1:0] edge_delta;
  logic sclk_meta_q;
  logic sclk_lvl_q;
  arsp_state_type state_q;
  arsp_state_type state_d;
  logic [8:0] cyc_q;
  logic [12:0] hold_q;
  logic [12:0] tmr_q;
  logic [12:0] tmr_d;
  logic [4:0] ptr_q;
  logic [5:0] ptr_sum;
  arsp_result_type output_result_register_q;
  arsp_result_type sat_result;
  logic shifting;
  logic line_d;
  logic hold_hit;

  // link side: only the falling-edge count lives on the serial clock
  arsp_sclk_edge_counter u_edge_counter (
    .sclk(sclk),
    .rst_n(rst_n),
    .edge_gray_q(edge_gray)
  );

  // two flops per gray bit before anything looks at the count
  generate
    for (genvar g = 0; g < EW; g++) begin : g_edge_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          edge_meta_q[g] <= 1'b0;
          edge_sync_q[g] <= 1'b0;
        end else begin
          edge_meta_q[g] <= edge_gray[g];
          edge_sync_q[g] <= edge_meta_q[g];
        end
      end
    end
  endgenerate

  // serial clock level, two flops; feeds the held-high timer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_meta_q <= 1'b0;
      sclk_lvl_q <= 1'b0;
    end else begin
      sclk_meta_q <= sclk;
      sclk_lvl_q <= sclk_meta_q;
    end
  end

  // new falling edges seen since the previous clock
  assign edge_delta = gray_to_bin(edge_sync_q) - edge_bin_prev_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      edge_bin_prev_q <= '0;
    end else begin
      edge_bin_prev_q <= gray_to_bin(edge_sync_q);
    end
  end

  // held-high timer; saturates at the trigger so it never wraps
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (!sclk_lvl_q) begin
      hold_q <= '0;
    end else if (hold_q != HOLD_TRIG) begin
      hold_q <= hold_q + 13'h0001;
    end
  end

  // trigger on the 1537th held-high clock: four full cycles have passed
  assign hold_hit = sclk_lvl_q && (hold_q == HOLD_TRIG - 13'h0001);

  // sequencer: run, sync pulse, sync hold, power-down, wake
  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q;
    case (state_q)
      ARSP_RUN: begin
        if (hold_hit) begin
          state_d = ARSP_SYNC_PULSE;
          tmr_d = '0;
        end
      end
      ARSP_SYNC_PULSE: begin
        if (tmr_q == PULSE_LAST) begin
          state_d = ARSP_SYNC_HOLD;
          tmr_d = '0;
        end else begin
          tmr_d = tmr_q + 13'h0001;
        end
      end
      ARSP_SYNC_HOLD: begin
        if (!sclk_lvl_q) begin
          state_d = ARSP_WAKE;
          tmr_d = WAKE_SYNC_LAST;
        end else if (tmr_q == GAP_LAST) begin
          state_d = ARSP_POWER_DOWN;
          tmr_d = '0;
        end else begin
          tmr_d = tmr_q + 13'h0001;
        end
      end
      ARSP_POWER_DOWN: begin
        if (!sclk_lvl_q) begin
          state_d = ARSP_WAKE;
          tmr_d = WAKE_PD_LAST;
        end
      end
      ARSP_WAKE: begin
        if (tmr_q == 13'h0000) begin
          state_d = ARSP_RUN;
        end else begin
          tmr_d = tmr_q - 13'h0001;
        end
      end
      default: begin
        state_d = ARSP_RUN;
        tmr_d = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ARSP_RUN;
      tmr_q <= '0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
    end
  end

  // conversion cycle position; restarts at the ready phase after any wake
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= '0;
    end else if (state_q != ARSP_RUN) begin
      cyc_q <= '0;
    end else if (cyc_q == CYC_LAST) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + 9'h001;
    end
  end

  assign shifting = (state_q == ARSP_RUN) && (cyc_q >= CYC_READY_END);

  // out-of-range filter sums clip to the full-scale codes
  always_comb begin
    if (filter_sum[`ARSP_SUM_W-1] != filter_sum[`ARSP_SUM_W-2]) begin
      sat_result = filter_sum[`ARSP_SUM_W-1] ? `ARSP_NEG_FS_CODE : `ARSP_POS_FS_CODE;
    end else begin
      sat_result = filter_sum[`ARSP_RESULT_W-1:0];
    end
  end

  // output register loaded at the last clock of the write window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      output_result_register_q <= `ARSP_ZERO_CODE;
    end else if (state_q == ARSP_RUN && cyc_q == CYC_WRITE) begin
      output_result_register_q <= sat_result;
    end
  end

  // pointer held at zero outside shift-out, so each read starts at the msb
  assign ptr_sum = {1'b0, ptr_q} + {2'b00, edge_delta};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= '0;
    end else if (!shifting) begin
      ptr_q <= '0;
    end else if (ptr_sum >= {1'b0, PTR_DONE}) begin
      ptr_q <= PTR_DONE;
    end else begin
      ptr_q <= ptr_sum[4:0];
    end
  end

  // line value: ready pattern, shifted bit, or the request pulse
  always_comb begin
    line_d = 1'b1;
    case (state_q)
      ARSP_RUN: begin
        if (cyc_q < CYC_T4_END) begin
          line_d = 1'b1;
        end else if (cyc_q < CYC_LOW_END) begin
          line_d = 1'b0;
        end else if (cyc_q < CYC_READY_END) begin
          line_d = 1'b1;
        end else if (ptr_q >= PTR_DONE) begin
          line_d = 1'b0;
        end else begin
          line_d = result_bit(output_result_register_q, ptr_q);
        end
      end
      ARSP_SYNC_PULSE: line_d = 1'b0;
      ARSP_SYNC_HOLD: line_d = 1'b1;
      ARSP_POWER_DOWN: line_d = 1'b1;
      ARSP_WAKE: line_d = 1'b1;
      default: line_d = 1'b1;
    endcase
  end

  // all outputs registered; one clock behind the sequencer, which the checks allow for
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      combined_result_line <= 1'b1;
      result_ready_phase <= 1'b0;
      modulator_reset <= 1'b0;
      power_down <= 1'b0;
    end else begin
      combined_result_line <= line_d;
      result_ready_phase <= (state_q == ARSP_RUN) && (cyc_q < CYC_READY_END);
      modulator_reset <= (state_q == ARSP_SYNC_PULSE) || (state_q == ARSP_SYNC_HOLD) ||
                         (state_q == ARSP_POWER_DOWN);
      power_down <= (state_q == ARSP_POWER_DOWN);
    end
  end

  // checks

  sequence s_sync_pulse;
    !combined_result_line [*3] ##1 combined_result_line;
  endsequence

  sequence s_ready_low_then_high;
    !combined_result_line [*6] ##1 combined_result_line [*6];
  endsequence

  chk_cycle_wrap: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_q == ARSP_RUN && cyc_q == CYC_LAST) |=> (cyc_q == 9'h000))
    else $error("conversion cycle did not wrap after 384 clocks");

  chk_ready_head_high: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_q == ARSP_RUN && cyc_q < CYC_T4_END) |=> combined_result_line)
    else $error("line not high at start of ready phase");

  chk_ready_pulse_shape: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_q == ARSP_RUN && cyc_q == CYC_T4_END && !hold_hit) |=> s_ready_low_then_high)
    else $error("ready pulse not low 6 then high 6");

  chk_msb_first: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_q == ARSP_RUN && cyc_q == CYC_READY_END) |=> (combined_result_line == output_result_register_q[23]))
    else $error("first shifted bit is not the msb");

  chk_overrun_low: assert property (
    @(posedge clock) disable iff (!rst_n)
    (shifting && ptr_q == PTR_DONE && !hold_hit) |=> !combined_result_line)
    else $error("line not low after 24 serial clocks");

  chk_shift_step: assert property (
    @(posedge clock) disable iff (!rst_n)
    (shifting && cyc_q != CYC_LAST && !hold_hit && edge_delta == 4'h1 && ptr_q < PTR_DONE)
    |=> (ptr_q == $past(ptr_q) + 5'h01))
    else $error("pointer did not advance on a serial falling edge");

  chk_sync_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(state_q == ARSP_SYNC_PULSE) |=> s_sync_pulse)
    else $error("request pulse is not 3 clocks low");

  chk_sync_start: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(modulator_reset) |-> (hold_q >= 13'h0601 && hold_q <= 13'h1DFF))
    else $error("sync started outside its held-high window");

  chk_pd_entry: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(power_down) |-> (sclk_lvl_q && $past(tmr_q, 2) == GAP_LAST))
    else $error("power-down entered at the wrong time");

  chk_wake_sync: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_q == ARSP_SYNC_HOLD && !sclk_lvl_q) |-> ##204 (state_q == ARSP_RUN && cyc_q == 9'h000))
    else $error("ready phase after sync not 203 clocks late");

  chk_write_before_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_q == ARSP_RUN && cyc_q == CYC_WRITE_START) |-> ##6 (cyc_q == CYC_T4_END || state_q != ARSP_RUN))
    else $error("write window not 6 clocks before the low pulse");

endmodule // arsp_result_port

// ---- bench/arsp_reader_model.sv ----
// arsp_reader_model: behavioural reader on the far side of the result line.
// assumes: link_clock is the reader's own clock; sclk idles low outside frames.
`timescale 1ns/1ps

module arsp_reader_model (
  input wire logic link_clock,
  input wire logic result_line,
  output logic sclk
);
  initial sclk = 1'b0;

  // latch on rising sclk, device moves to next bit after the fall
  task automatic read_bits(input int n, output logic [31:0] word);
    word = '0;
    repeat (3) @(posedge link_clock); // setup after ready phase ends
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      word = {word[30:0], result_line};
      @(posedge link_clock);
      sclk = 1'b0;
      repeat (4) @(posedge link_clock); // answer needs up to 20 ns, so wait well past it
    end
  endtask // whole word fits before the next ready phase

  // level requests for sync and power-down
  task automatic hold_high;
    @(posedge link_clock);
    sclk = 1'b1;
  endtask

  task automatic release_low;
    @(posedge link_clock);
    sclk = 1'b0;
  endtask
endmodule // arsp_reader_model

// ---- bench/adc_serial_result_port_tb.sv ----
// adc_serial_result_port_tb: self-checking bench for the serial result port.
// assumes: design files under design/; reader model drives sclk on its own clock.
`timescale 1ns/1ps

module adc_serial_result_port_tb;
  localparam int PD_GAP = 20;
  logic clock, link_clock, rst_n, sclk;
  logic [24:0] filter_sum;
  logic combined_result_line, result_ready_phase, modulator_reset, power_down;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [24:0] sums [7] = '{25'h0000000, 25'h0000001, 25'h1FFFFFF, 25'h07FFFFF,
                            25'h1800000, 25'h0FFFFFF, 25'h1000000};

  arsp_result_port #(.PD_GAP_CLK(PD_GAP)) i_arsp_result_port (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .filter_sum(filter_sum),
    .combined_result_line(combined_result_line), .result_ready_phase(result_ready_phase),
    .modulator_reset(modulator_reset), .power_down(power_down));

  arsp_reader_model i_arsp_reader_model (
    .link_clock(link_clock), .result_line(combined_result_line), .sclk(sclk));

  // 200 MHz master clock and unrelated 12 ns link clock
  always #2.5 clock = ~clock;
  always #6 link_clock = ~link_clock;

  // hang guard, well above the roughly 12k cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude;
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // bounded wait on the ready indicator, counting falling clock edges
  task automatic wait_ready(input logic lvl, output int n);
    n = 0;
    while (result_ready_phase !== lvl && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000)
      check_range(n, 0, 2999);
  endtask

  // saturation of the wide filter sum into the 24-bit code range
  function automatic logic [23:0] clip(input logic signed [24:0] s);
    if (s > 25'sh07FFFFF)
      return 24'h7FFFFF;
    if (s < -25'sh0800000)
      return 24'h800000;
    return s[23:0];
  endfunction

  // load a sum, let it reach the output register, read n bits
  task automatic read_check(input logic [24:0] sum, input int n);
    logic [31:0] got, exp;
    logic [23:0] e;
    int w;
    @(negedge clock);
    filter_sum = sum;
    e = clip(sum);
    exp = '0;
    for (int i = 0; i < n; i++)
      exp = {exp[30:0], (i < 24) ? e[23 - i] : 1'b0}; // bits past 24 read low
    wait_ready(1'b0, w);
    wait_ready(1'b1, w);
    wait_ready(1'b0, w);
    i_arsp_reader_model.read_bits(n, got);
    check_word(got, exp);
  endtask

  // ready phase shape and cycle length
  task automatic frame_shape;
    int w;
    wait_ready(1'b0, w);
    wait_ready(1'b1, w);
    for (int i = 0; i < 36; i++) begin
      check_word({31'h0, combined_result_line}, (i < 24 || i >= 30) ? 32'h1 : 32'h0);
      @(negedge clock);
    end
    check_word({31'h0, result_ready_phase}, 32'h0);
    wait_ready(1'b1, w);
    check_range(w + 36, 384, 384);
  endtask

  // hold sclk high, check the pulse, optionally reach power-down, then wake
  task automatic sync_case(input logic pd);
    int w;
    logic [3:0] hist;
    hist = 4'hF;
    w = 0;
    wait_ready(1'b0, w);
    i_arsp_reader_model.hold_high();
    do begin
      @(negedge clock);
      hist = {hist[2:0], combined_result_line};
      w++;
    end while (modulator_reset !== 1'b1 && w < 8000);
    check_range(w, 1537, 7679);
    // reset flag rises with the first low clock; collect the rest of the pulse and its end
    repeat (3) begin
      @(negedge clock);
      hist = {hist[2:0], combined_result_line};
    end
    check_word({28'h0, hist}, 32'h1);
    if (pd) begin
      w = 0;
      while (power_down !== 1'b1 && w < 100) begin
        @(negedge clock);
        w++;
      end
      check_range(w, PD_GAP - 1, PD_GAP + 2);
    end
    check_word({31'h0, combined_result_line}, 32'h1);
    check_word({31'h0, power_down}, {31'h0, pd});
    i_arsp_reader_model.release_low();
    wait_ready(1'b1, w);
    if (pd)
      check_range(w, 2319, 2325);
    else
      check_range(w, 203, 209);
    check_word({30'h0, modulator_reset, power_down}, 32'h0);
  endtask

  // main sequence
  initial begin
    clock = 1'b0;
    link_clock = 1'b0;
    rst_n = 1'b0;
    filter_sum = '0;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    for (int k = 0; k < 7; k++)
      read_check(sums[k], 24);
    read_check(25'h00ABCDE, 10);
    read_check(25'h1A5A5A5, 24);
    read_check(25'h0555555, 26);
    check_word({31'h0, combined_result_line}, 32'h0);
    frame_shape();
    sync_case(1'b0);
    read_check(25'h0000042, 24);
    sync_case(1'b1);
    read_check(25'h1F00F0F, 24);
    conclude();
  end
endmodule // adc_serial_result_port_tb
